// [rtl/sorb_consts.svh]
`ifndef SORB_CONSTS_SVH
`define SORB_CONSTS_SVH
// register byte offsets
`define SORB_ADDR_CTRL    8'h00
`define SORB_ADDR_REQ     8'h04
`define SORB_ADDR_ALLOC   8'h08
`define SORB_ADDR_STATUS  8'h0C
`define SORB_ADDR_TOTAL   8'h10
// control field positions
`define SORB_CTRL_START   0
`define SORB_CTRL_OPT_LO  4
`define SORB_CTRL_OPT_HI  6
`define SORB_CTRL_RET_TO  8
// reset values
`define SORB_OPT_RST      3'h0
`define SORB_ALLOC_RST    32'h0000_0000
// reporting options
`define SORB_OPT_ALL      3'h0
`define SORB_OPT_ONE_OP   3'h1
`define SORB_OPT_ONE_SA   3'h2
`define SORB_OPT_ONE_ANY  3'h3
// support codes
`define SORB_SUP_NA       3'h0
`define SORB_SUP_NOT      3'h1
`define SORB_SUP_STD      3'h3
`define SORB_SUP_VEND     3'h5
// layout sizes in bytes, plus command count and last table index
`define SORB_NUM_CMDS     16'h0004
`define SORB_LAST_IDX     2'h3
`define SORB_HDR_BYTES    16'h0004
`define SORB_DESC_BYTES   16'h0008
`define SORB_TD_BYTES     16'h000C
`define SORB_TD_LEN       8'h0A
// supported command table
`define SORB_OP_TUR       8'h00
`define SORB_OP_READ10    8'h28
`define SORB_OP_WBUF      8'h3B
`define SORB_OP_RSOC      8'hA3
`define SORB_SA_RSOC      16'h000C
`define SORB_LEN6         8'h06
`define SORB_LEN10        8'h0A
`define SORB_LEN12        8'h0C
// timeouts in seconds, processing time only
`define SORB_TO_TUR_NOM   32'h0000_0001
`define SORB_TO_TUR_REC   32'h0000_0005
`define SORB_TO_RD_NOM    32'h0000_0002
`define SORB_TO_RD_REC    32'h0000_001E
`define SORB_TO_WB_NOM    32'h0000_000A
`define SORB_TO_WB_REC    32'h0000_003C
`define SORB_TO_RS_NOM    32'h0000_0001
`define SORB_TO_RS_REC    32'h0000_0005
`define SORB_WB_LOSS_S    8'h1E
`endif

// [rtl/sorb_pkg.sv]
package sorb_pkg;
  // gray along idle -> search -> send -> drain -> idle
  typedef enum logic [1:0] {
    SORB_IDLE   = 2'h0,
    SORB_SEARCH = 2'h1,
    SORB_SEND   = 2'h3,
    SORB_DRAIN  = 2'h2
  } sorb_state_t;

  typedef struct packed {
    sorb_state_t st;
    logic [2:0]  opt;
    logic        return_timeouts_request;
    logic [7:0]  req_op;
    logic [15:0] req_sa;
    logic [31:0] alloc;
    logic        busy;
    logic        done;
    logic        err;
    logic [1:0]  idx;
    logic [4:0]  off;
    logic [15:0] pos;
    logic [2:0]  sup;
    logic [15:0] total;
    logic [15:0] send_len;
    logic        ovalid;
    logic [7:0]  odata;
    logic        olast;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } sorb_regs_t;
endpackage

// [rtl/sorb_cmd_rom.sv]
`include "sorb_consts.svh"
module sorb_cmd_rom (
  input  wire logic [1:0]  idx,
  output logic      [7:0]  op,
  output logic      [15:0] sa,
  output logic             has_sa,
  output logic      [7:0]  cdb_len,
  output logic      [7:0]  cspec,
  output logic      [31:0] nom,
  output logic      [31:0] rec
);
  // one row per supported cdb; cspec zero where it has no meaning
  always_comb begin
    op      = `SORB_OP_TUR;
    sa      = 16'h0000;
    has_sa  = 1'h0;
    cdb_len = `SORB_LEN6;
    cspec   = 8'h00;
    nom     = `SORB_TO_TUR_NOM;
    rec     = `SORB_TO_TUR_REC;
    case (idx)
      2'h1: begin
        op      = `SORB_OP_READ10;
        cdb_len = `SORB_LEN10;
        nom     = `SORB_TO_RD_NOM;
        rec     = `SORB_TO_RD_REC;
      end
      2'h2: begin
        op      = `SORB_OP_WBUF;
        cdb_len = `SORB_LEN10;
        cspec   = `SORB_WB_LOSS_S;
        nom     = `SORB_TO_WB_NOM;
        rec     = `SORB_TO_WB_REC;
      end
      2'h3: begin
        op      = `SORB_OP_RSOC;
        sa      = `SORB_SA_RSOC;
        has_sa  = 1'h1;
        cdb_len = `SORB_LEN12;
        nom     = `SORB_TO_RS_NOM;
        rec     = `SORB_TO_RS_REC;
      end
      default: begin
      end
    endcase
  end
endmodule // sorb_cmd_rom

// [rtl/sorb_usage_rom.sv]
module sorb_usage_rom (
  input  wire logic [1:0] idx,
  input  wire logic [3:0] bidx,
  output logic      [7:0] usage
);
  // cdb usage maps; byte 0 opcode, sa kept at its cdb spot
  always_comb begin
    case ({idx, bidx})
      6'h10: usage = 8'h28;
      6'h11: usage = 8'hFA;
      6'h12, 6'h13, 6'h14, 6'h15: usage = 8'hFF;
      6'h16: usage = 8'h1F;
      6'h17, 6'h18: usage = 8'hFF;
      6'h20: usage = 8'h3B;
      6'h21: usage = 8'h1F;
      6'h22, 6'h23, 6'h24, 6'h25: usage = 8'hFF;
      6'h26, 6'h27, 6'h28: usage = 8'hFF;
      6'h30: usage = 8'hA3;
      6'h31: usage = 8'h0C;
      6'h32: usage = 8'h87;
      6'h33, 6'h34, 6'h35, 6'h36: usage = 8'hFF;
      6'h37, 6'h38, 6'h39: usage = 8'hFF;
      default: usage = 8'h00;
    endcase
  end
endmodule // sorb_usage_rom

// [rtl/sorb_builder.sv]
// Operation
// R1 - all-commands data starts with four-byte length header, then descriptors
// R2 - header length counts every byte after the four-byte header
// R3 - one descriptor per supported opcode and service action pair
// R4 - descriptor: opcode, sa bytes 2-3, cdb length 6-7, timeouts 8-19
// R5 - service action field is zero when opcode has no service action
// R6 - timeouts-present flag set exactly when a timeouts descriptor follows
// R7 - sa-valid flag set when opcode has service actions
// R8 - cdb length field gives the command's cdb byte count
// R9 - one-command: reserved, flag plus support, size, usage, timeouts
// R10 - support codes 000b, 001b, 011b, 101b; others reserved
// R11 - after byte 1 data invalid for support 000b or 001b
// R12 - cdb size equals usage length and cdb byte count
// R13 - usage byte 0 holds opcode; sa at its cdb position
// R14 - usage bits mirror cdb: one where evaluated, else zero
// R15 - timeouts descriptor begins with two-byte length 0Ah
// R16 - reserved, command specific, nominal bytes 4-7, recommended 8-11
// R17 - timeouts cover processing only, excluding outside delays
// R18 - power transition time left out of timeouts
// R19 - command specific byte reserved where it has no meaning
// R20 - buffer-write microcode modes report access-loss seconds there
// R21 - option 000b all-commands; 001b-011b one-command format
// R22 - timeouts descriptors only when return-timeouts request bit set
// R23 - data truncated to the allocation length
// R24 - multi-byte fields sent most significant byte first
`include "sorb_consts.svh"
module sorb_builder (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             out_valid,
  output logic      [7:0]  out_data,
  output logic             out_last,
  input  wire logic        out_ready
);
  sorb_pkg::sorb_regs_t q;
  sorb_pkg::sorb_regs_t d;

  logic [7:0]  rom_op;
  logic [15:0] rom_sa;
  logic        rom_has_sa;
  logic [7:0]  rom_len;
  logic [7:0]  rom_cspec;
  logic [31:0] rom_nom;
  logic [31:0] rom_rec;
  logic [7:0]  usage;
  logic [15:0] upos;
  logic [15:0] tdi;
  logic [15:0] dsz;
  logic [15:0] tot;
  logic [15:0] hdr_len;
  logic [7:0]  byte_c;
  logic        all_mode;
  logic        ld;
  logic        acc;
  logic        op_hit;
  logic        sa_ok;

  // timeouts descriptor byte k, big-endian fields
  function automatic logic [7:0] td_byte(
    input logic [4:0]  k,
    input logic [7:0]  cs,
    input logic [31:0] nom,
    input logic [31:0] rec
  );
    logic [7:0] b;
    case (k)
      5'h01: b = `SORB_TD_LEN; // [R15]
      5'h03: b = cs; // [R19] [R20]
      5'h04: b = nom[31:24]; // [R16] [R24]
      5'h05: b = nom[23:16];
      5'h06: b = nom[15:8];
      5'h07: b = nom[7:0];
      5'h08: b = rec[31:24];
      5'h09: b = rec[23:16];
      5'h0A: b = rec[15:8];
      5'h0B: b = rec[7:0];
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  // table values exclude power transitions and foreign delays [R17] [R18]
  sorb_cmd_rom u_cmd (
    .idx     (q.idx),
    .op      (rom_op),
    .sa      (rom_sa),
    .has_sa  (rom_has_sa),
    .cdb_len (rom_len),
    .cspec   (rom_cspec),
    .nom     (rom_nom),
    .rec     (rom_rec)
  );

  sorb_usage_rom u_usage (
    .idx   (q.idx),
    .bidx  (upos[3:0]),
    .usage (usage)
  );

  // byte at the current position of the parameter data
  always_comb begin
    all_mode = (q.opt == `SORB_OPT_ALL);
    dsz      = `SORB_DESC_BYTES +
               (q.return_timeouts_request ? `SORB_TD_BYTES : 16'h0000);
    upos     = q.pos - `SORB_HDR_BYTES;
    tdi      = upos - {8'h00, rom_len};
    hdr_len  = q.total - `SORB_HDR_BYTES; // [R2]
    byte_c   = 8'h00;
    if (all_mode) begin
      if (q.pos < `SORB_HDR_BYTES) begin
        case (q.pos[1:0]) // [R1] [R24]
          2'h2: byte_c = hdr_len[15:8];
          2'h3: byte_c = hdr_len[7:0];
          default: byte_c = 8'h00;
        endcase
      end else begin
        case (q.off) // [R4]
          5'h00: byte_c = rom_op;
          5'h02: byte_c = rom_has_sa ? rom_sa[15:8] : 8'h00; // [R5]
          5'h03: byte_c = rom_has_sa ? rom_sa[7:0] : 8'h00; // [R5]
          5'h05: byte_c = {6'h00, q.return_timeouts_request,
                           rom_has_sa}; // [R6] [R7]
          5'h07: byte_c = rom_len; // [R8]
          default: begin
            if (q.off >= 5'h08)
              byte_c = td_byte(q.off - 5'h08, rom_cspec, rom_nom, rom_rec);
          end
        endcase
      end
    end else begin
      // unsupported answers stop at a zero size [R11]
      case (q.pos)
        16'h0001: byte_c = {q.return_timeouts_request &&
                            q.sup == `SORB_SUP_STD, 4'h0,
                            q.sup}; // [R9] [R6] [R10]
        16'h0003: byte_c = (q.sup == `SORB_SUP_STD) ? rom_len : 8'h00;
        16'h0000, 16'h0002: byte_c = 8'h00; // [R12]
        default: begin
          if (upos < {8'h00, rom_len})
            byte_c = usage; // [R13] [R14]
          else
            byte_c = td_byte(tdi[4:0], rom_cspec, rom_nom, rom_rec);
        end
      endcase
    end
  end

  // next state: apb slave, search, stream out
  always_comb begin
    d         = q;
    d.pready  = 1'h0;
    d.pslverr = 1'h0;
    acc       = psel && penable && !q.pready;
    ld        = (q.st == sorb_pkg::SORB_SEND) && (!q.ovalid || out_ready);
    op_hit    = (rom_op == q.req_op);
    // option 011b treats sa 00h as match for non-sa opcodes
    sa_ok     = rom_has_sa ? (q.opt == `SORB_OPT_ONE_OP ||
                              rom_sa == q.req_sa)
                           : (q.opt != `SORB_OPT_ONE_ANY ||
                              q.req_sa == 16'h0000);
    tot       = `SORB_HDR_BYTES;
    // two-cycle access keeps prdata and pready registered
    if (acc) begin
      d.pready = 1'h1;
      d.prdata = 32'h0000_0000;
      case (paddr)
        `SORB_ADDR_CTRL: begin
          d.prdata = {23'h0, q.return_timeouts_request, 1'h0, q.opt,
                      4'h0};
          if (pwrite && !q.busy) begin
            d.opt  = pwdata[`SORB_CTRL_OPT_HI:`SORB_CTRL_OPT_LO];
            d.return_timeouts_request = pwdata[`SORB_CTRL_RET_TO];
            if (pwdata[`SORB_CTRL_START]) begin
              d.st   = sorb_pkg::SORB_SEARCH;
              d.busy = 1'h1;
              d.done = 1'h0;
              d.err  = 1'h0;
              d.idx  = 2'h0;
              d.off  = 5'h00;
              d.pos  = 16'h0000;
            end
          end
        end
        `SORB_ADDR_REQ: begin
          d.prdata = {8'h00, q.req_sa, q.req_op};
          if (pwrite && !q.busy) begin
            d.req_op = pwdata[7:0];
            d.req_sa = pwdata[23:8];
          end
        end
        `SORB_ADDR_ALLOC: begin
          d.prdata = q.alloc;
          if (pwrite && !q.busy)
            d.alloc = pwdata;
        end
        `SORB_ADDR_STATUS: d.prdata = {29'h0, q.err, q.done, q.busy};
        `SORB_ADDR_TOTAL:  d.prdata = {16'h0000, q.total};
        default: d.pslverr = 1'h1;
      endcase
    end
    case (q.st)
      sorb_pkg::SORB_SEARCH: begin
        if (all_mode) begin
          // every table row is reported [R3] [R21] [R22]
          tot = `SORB_HDR_BYTES + 16'(`SORB_NUM_CMDS * dsz);
          d.st = sorb_pkg::SORB_SEND;
        end else if (q.opt > `SORB_OPT_ONE_ANY) begin
          d.st   = sorb_pkg::SORB_IDLE;
          d.err  = 1'h1;
          d.busy = 1'h0;
          d.done = 1'h1;
        end else if (op_hit && sa_ok) begin
          // wrong option for this opcode is an illegal request
          if ((q.opt == `SORB_OPT_ONE_OP && rom_has_sa) ||
              (q.opt == `SORB_OPT_ONE_SA && !rom_has_sa)) begin
            d.st   = sorb_pkg::SORB_IDLE;
            d.err  = 1'h1;
            d.busy = 1'h0;
            d.done = 1'h1;
          end else begin
            d.sup = `SORB_SUP_STD; // [R10]
            tot = `SORB_HDR_BYTES + {8'h00, rom_len} +
                  (q.return_timeouts_request ? `SORB_TD_BYTES :
                   16'h0000); // [R9] [R22]
            d.st = sorb_pkg::SORB_SEND;
          end
        end else if (q.idx == `SORB_LAST_IDX) begin
          d.sup = `SORB_SUP_NOT; // [R10]
          d.st  = sorb_pkg::SORB_SEND;
        end else begin
          d.idx = q.idx + 2'h1;
        end
        if (d.st == sorb_pkg::SORB_SEND) begin
          d.total    = tot;
          d.send_len = (q.alloc < {16'h0000, tot}) ?
                       q.alloc[15:0] : tot; // [R23]
          if (all_mode)
            d.idx = 2'h0;
          if (q.alloc == 32'h0000_0000) begin
            d.st   = sorb_pkg::SORB_IDLE;
            d.busy = 1'h0;
            d.done = 1'h1;
          end
        end
      end
      sorb_pkg::SORB_SEND: begin
        if (ld) begin
          d.ovalid = 1'h1;
          d.odata  = byte_c;
          d.olast  = (q.pos == q.send_len - 16'h0001); // [R23]
          d.pos    = q.pos + 16'h0001;
          if (all_mode && q.pos >= `SORB_HDR_BYTES) begin
            if ({11'h000, q.off} == dsz - 16'h0001) begin
              d.off = 5'h00;
              d.idx = q.idx + 2'h1; // [R3]
            end else begin
              d.off = q.off + 5'h01;
            end
          end
          if (d.olast)
            d.st = sorb_pkg::SORB_DRAIN;
        end
      end
      sorb_pkg::SORB_DRAIN: begin
        if (out_ready) begin
          d.ovalid = 1'h0;
          d.olast  = 1'h0;
          d.st     = sorb_pkg::SORB_IDLE;
          d.busy   = 1'h0;
          d.done   = 1'h1;
        end
      end
      default: begin
      end
    endcase
  end

  // state register; synchronous reset to idle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      q          <= '0;
      q.st       <= sorb_pkg::SORB_IDLE;
      q.opt      <= `SORB_OPT_RST;
      q.alloc    <= `SORB_ALLOC_RST;
    end else begin
      q <= d;
    end
  end

  assign prdata    = q.prdata;
  assign pready    = q.pready;
  assign pslverr   = q.pslverr;
  assign out_valid = q.ovalid;
  assign out_data  = q.odata;
  assign out_last  = q.olast;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence s_search_go;
    q.st == sorb_pkg::SORB_SEARCH &&
      $past(q.st) == sorb_pkg::SORB_IDLE;
  endsequence
  sequence s_search_left;
    q.st != sorb_pkg::SORB_SEARCH;
  endsequence

  AST_SEARCH_BOUND: assert property ( // [R21]
    s_search_go |-> ##[1:5] s_search_left)
    else $error("search did not finish in five cycles");
  AST_HDR_LEN: assert property ( // [R2]
    ld && all_mode && q.pos == 16'h0003 |=>
      out_data == 8'(q.total - 16'h0004) && !out_last ||
      q.send_len == 16'h0004)
    else $error("header length byte wrong");
  AST_SA_ZERO: assert property ( // [R5]
    ld && all_mode && q.pos >= 16'h0004 && !rom_has_sa &&
      (q.off == 5'h02 || q.off == 5'h03) |-> byte_c == 8'h00)
    else $error("service action not zero");
  AST_TD_PRESENT_ALL: assert property ( // [R6]
    ld && all_mode && q.pos >= 16'h0004 && q.off == 5'h05 |->
      byte_c[1] == q.return_timeouts_request &&
      byte_c[0] == rom_has_sa)
    else $error("descriptor flags wrong");
  AST_TD_LEN: assert property ( // [R15]
    ld && all_mode && q.pos >= 16'h0004 && q.off == 5'h09 |->
      q.return_timeouts_request && byte_c == 8'h0A)
    else $error("timeouts length not 0Ah");
  AST_SUP_CODE: assert property ( // [R10]
    ld && !all_mode && q.pos == 16'h0001 |->
      byte_c[2:0] == 3'h1 || byte_c[2:0] == 3'h3)
    else $error("support code illegal");
  AST_USAGE_OP: assert property ( // [R13]
    ld && !all_mode && q.pos == 16'h0004 |->
      q.sup == 3'h3 && byte_c == q.req_op)
    else $error("usage byte 0 not the opcode");
  AST_TRUNC: assert property ( // [R23]
    ld && q.pos == q.send_len - 16'h0001 |=>
      out_valid && out_last && q.st == sorb_pkg::SORB_DRAIN)
    else $error("last byte not at allocation bound");
  AST_HOLD: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_data) &&
      $stable(out_last))
    else $error("stream byte changed while stalled");
endmodule // sorb_builder

// [sim/sorb_host_sink.sv]
module sorb_host_sink (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       out_valid,
  input  wire logic [7:0] out_data,
  input  wire logic       out_last,
  input  wire logic       stall,
  output logic            out_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rx_q[$];
  int         last_cnt;
  int         last_at;
  logic [1:0] ph_q;
  initial begin
    out_ready = 1'b0;
    ph_q = 2'h0;
    last_cnt = 0;
    last_at = -1;
  end
  // bytes are stored blindly; invalid fields are not interpreted
  always @(posedge clk_sys) begin
    ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
    // slow mode takes one byte in three so the stream must hold
    out_ready <= !sys_rst && (!stall || ph_q == 2'h1);
    if (out_valid && out_ready) begin
      rx_q.push_back(out_data);
      if (out_last) begin
        last_cnt++;
        last_at = rx_q.size() - 1;
      end
    end
  end
endmodule // sorb_host_sink

// [sim/supported_opcode_report_builder_tb.sv]
`include "sorb_consts.svh"
module supported_opcode_report_builder_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  paddr   = 8'h00;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic        stall   = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        out_valid;
  logic [7:0]  out_data;
  logic        out_last;
  logic        out_ready;
  int          num_errors = 0;
  int          n_compared = 0;
  logic [7:0]  exp_q[$];
  bit          care_q[$];
  logic [31:0] rd;
  logic        er;
  // command table as the device should report it
  localparam logic [7:0] OPS [4] = '{`SORB_OP_TUR, `SORB_OP_READ10,
                                     `SORB_OP_WBUF, `SORB_OP_RSOC};
  localparam logic [7:0] LENS [4] = '{`SORB_LEN6, `SORB_LEN10,
                                      `SORB_LEN10, `SORB_LEN12};
  localparam logic [7:0] CSS [4] = '{8'h00, 8'h00, `SORB_WB_LOSS_S, 8'h00};
  localparam logic [31:0] NOM [4] = '{`SORB_TO_TUR_NOM, `SORB_TO_RD_NOM,
                                      `SORB_TO_WB_NOM, `SORB_TO_RS_NOM};
  localparam logic [31:0] REC [4] = '{`SORB_TO_TUR_REC, `SORB_TO_RD_REC,
                                      `SORB_TO_WB_REC, `SORB_TO_RS_REC};

  sorb_builder sorb_builder_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .out_valid(out_valid),
    .out_data(out_data), .out_last(out_last), .out_ready(out_ready));

  sorb_host_sink sorb_host_sink_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .out_valid(out_valid),
    .out_data(out_data), .out_last(out_last), .stall(stall),
    .out_ready(out_ready));

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // apb transfer; waits for pready, never assumes a latency
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 32'h0, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // expected bytes go out most significant first
  task automatic put(input logic [31:0] v, input int nb, input bit c = 1);
    for (int i = nb - 1; i >= 0; i--) begin
      exp_q.push_back(v[8*i+:8]);
      care_q.push_back(c);
    end
  endtask

  task automatic td(input int i);
    put(`SORB_TD_LEN, 2);
    put(32'h0, 1);
    put(CSS[i], 1);
    put(NOM[i], 4);
    put(REC[i], 4);
  endtask

  task automatic exp_all(input logic rc);
    exp_q.delete();
    care_q.delete();
    put(4 * (8 + 12 * rc), 4);
    for (int i = 0; i < 4; i++) begin
      put(OPS[i], 1);
      put(32'h0, 1);
      put(i == 3 ? `SORB_SA_RSOC : 16'h0000, 2);
      put(32'h0, 1);
      put({rc, i == 3}, 1);
      put(LENS[i], 2);
      if (rc) td(i);
    end
  endtask

  task automatic exp_one(input logic rc, input int i);
    exp_q.delete();
    care_q.delete();
    put({rc, 4'h0, `SORB_SUP_STD}, 2);
    put(LENS[i], 2);
    put(OPS[i], 1);
    if (i == 3) put(`SORB_SA_RSOC, 1);
    put(32'h0, LENS[i] - 1 - (i == 3), 0);
    if (rc) td(i);
  endtask

  // start one request and judge the stream against exp_q
  task automatic go(input logic [2:0] opt, input logic rc,
                    input logic [7:0] op, input logic [15:0] sa,
                    input logic [31:0] al, input logic [2:0] st);
    int n;
    int k;
    sorb_host_sink_inst.rx_q.delete();
    sorb_host_sink_inst.last_cnt = 0;
    apb(1'b1, `SORB_ADDR_REQ, {8'h00, sa, op});
    apb(1'b1, `SORB_ADDR_ALLOC, al);
    apb(1'b1, `SORB_ADDR_CTRL, {23'h0, rc, 1'b0, opt, 3'h0, 1'b1});
    if (stall) apb(1'b1, `SORB_ADDR_ALLOC, 32'h0000_0001);
    k = 0;
    do begin
      apb(1'b0, `SORB_ADDR_STATUS, 32'h0);
      k++;
    end while (rd[1] !== 1'b1 && k < 500);
    chk("status", {29'h0, rd[2:0]}, {29'h0, st});
    n = (al < exp_q.size()) ? al : exp_q.size();
    chk("count", sorb_host_sink_inst.rx_q.size(), n);
    for (int i = 0; i < n; i++)
      if (care_q[i]) chk("byte", sorb_host_sink_inst.rx_q[i], exp_q[i]);
    chk("last", sorb_host_sink_inst.last_cnt, n > 0);
    if (n > 0) chk("last at", sorb_host_sink_inst.last_at, n - 1);
    if (!st[2]) begin
      apb(1'b0, `SORB_ADDR_TOTAL, 32'h0);
      chk("total", {16'h0, rd[15:0]}, exp_q.size());
    end
    apb(1'b0, `SORB_ADDR_ALLOC, 32'h0);
    chk("alloc", rd, al);
  endtask

  task automatic t_regs();
    apb(1'b0, `SORB_ADDR_STATUS, 32'h0);
    chk("status rst", rd, 32'h0);
    apb(1'b0, `SORB_ADDR_ALLOC, 32'h0);
    chk("alloc rst", rd, `SORB_ALLOC_RST);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped err", er, 1'b1);
    chk("unmapped data", rd, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_all();
    exp_all(1'b0);
    stall <= 1'b1;
    go(`SORB_OPT_ALL, 1'b0, 8'h00, 16'h0, 32'h0000_0100, 3'h2);
    stall <= 1'b0;
    exp_all(1'b1);
    go(`SORB_OPT_ALL, 1'b1, 8'h00, 16'h0, 32'h0000_0054, 3'h2);
    go(`SORB_OPT_ALL, 1'b1, 8'h00, 16'h0, 32'h0000_001E, 3'h2);
    // zero allocation still reports the full length in total
    exp_all(1'b0);
    go(`SORB_OPT_ALL, 1'b0, 8'h00, 16'h0, 32'h0000_0000, 3'h2);
    $display("test all commands done");
  endtask

  task automatic t_one();
    exp_one(1'b1, 1);
    go(`SORB_OPT_ONE_OP, 1'b1, `SORB_OP_READ10, 16'h0, 32'hFF, 3'h2);
    exp_one(1'b0, 3);
    go(`SORB_OPT_ONE_SA, 1'b0, `SORB_OP_RSOC, `SORB_SA_RSOC, 32'hFF,
       3'h2);
    exp_one(1'b1, 2);
    go(`SORB_OPT_ONE_ANY, 1'b1, `SORB_OP_WBUF, 16'h0, 32'hFF, 3'h2);
    exp_one(1'b0, 0);
    go(`SORB_OPT_ONE_ANY, 1'b0, `SORB_OP_TUR, 16'h0, 32'hFF, 3'h2);
    exp_q.delete();
    care_q.delete();
    // reserved byte, support byte, then a zero cdb size
    put({8'h00, 5'h00, `SORB_SUP_NOT, 16'h0000}, 4);
    go(`SORB_OPT_ONE_ANY, 1'b1, 8'h12, 16'h0, 32'hFF, 3'h2);
    go(`SORB_OPT_ONE_ANY, 1'b0, `SORB_OP_RSOC, 16'h000D, 32'hFF,
       3'h2);
    $display("test one command done");
  endtask

  task automatic t_err();
    exp_q.delete();
    care_q.delete();
    for (int o = 4; o < 8; o++)
      go(o[2:0], 1'b0, 8'h00, 16'h0, 32'hFF, 3'h6);
    go(`SORB_OPT_ONE_OP, 1'b0, `SORB_OP_RSOC, 16'h0, 32'hFF, 3'h6);
    go(`SORB_OPT_ONE_SA, 1'b0, `SORB_OP_TUR, 16'h0, 32'hFF, 3'h6);
    $display("test refusals done");
  endtask

  // a hang counts as a mismatch and ends the run the usual way
  initial begin
    #1000000;
    num_errors++;
    close_out();
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_regs();
    t_all();
    t_one();
    t_err();
    close_out();
  end
endmodule // supported_opcode_report_builder_tb
